// ---- hdl/bph_params.svh ----
/*
  Constants for the power handshake unit: register offsets, field positions,
  reset values and timing figures.
  Assumes inclusion by bare name from the design file.
*/
`ifndef BPH_PARAMS_SVH
`define BPH_PARAMS_SVH

// Register byte offsets
`define BPH_CTRL_OFS      4'h0
`define BPH_PD_OFS        4'h4
`define BPH_STAT_OFS      4'h8
`define BPH_SLEEP_OFS     4'hc

// Control fields
`define BPH_CTRL_HS_EN    0
`define BPH_CTRL_DW_POL   1
`define BPH_CTRL_HW_POL   2
`define BPH_CTRL_HOSTREQ  3
`define BPH_CTRL_SLPOK    4
`define BPH_CTRL_GO_SLEEP 5
`define BPH_CTRL_RST      32'h0000_0001

// Power-down fields
`define BPH_PD_TX         0
`define BPH_PD_RX         1
`define BPH_PD_SYN        2
`define BPH_PD_PA         3
`define BPH_PD_RST        4'hf

// Sleep interval reset, in sleep-clock ticks
`define BPH_SLEEP_RST     16'h0020

// Timing
`define BPH_CLK_NS        50
`define BPH_CLKREQ_DLY_NS 10000
`define BPH_HOP_RATE      1600
`define BPH_CHANNELS      79
`define BPH_HOP_NS        (1000000000 / `BPH_HOP_RATE)
`define BPH_CLKREQ_CYC    ((`BPH_CLKREQ_DLY_NS + `BPH_CLK_NS - 1) / `BPH_CLK_NS)
`define BPH_HOP_CYC       (`BPH_HOP_NS / `BPH_CLK_NS)

`define BPH_RESP_OKAY     2'b00
`define BPH_RESP_SLVERR   2'b10

`endif

// ---- hdl/bph_pkg.sv ----
/*
  Types for the power handshake unit.
  Assumes bph_params.svh is on the include path.
*/
`default_nettype none
package bph_pkg;
  typedef enum logic [3:0] {
    BPH_ST_OFF   = 4'b0001,
    BPH_ST_START = 4'b0010,
    BPH_ST_AWAKE = 4'b0100,
    BPH_ST_SLEEP = 4'b1000
  } bph_state_t;
  typedef logic [31:0] bph_word_t;
endpackage : bph_pkg
`default_nettype wire

// ---- hdl/bph_power_unit.sv ----
/*
  Bluetooth power handshake unit: wake handshake with the host, reference-clock
  request, radio power-down controls and sleep timing, with AXI4-Lite registers.
  Assumes synchronous inputs, sleep-clock tick as a one-cycle pulse on CLOCK_I.
*/
// Our own choices: register access over AXI4-Lite and the register offsets.
`include "bph_params.svh"
`default_nettype none
module bph_power_unit #(
  parameter int CLKREQ_CYC = `BPH_CLKREQ_CYC,
  parameter int HOP_CYC    = `BPH_HOP_CYC
) (
  input  wire logic                CLOCK_I,
  input  wire logic                RST_N_I,
  input  wire logic                BT_POWER_ENABLE_I,
  input  wire logic                UART_MODE_I,
  input  wire logic                DEVICE_WAKE_IN_I,
  input  wire logic                WLAN_REFCLK_NEED_I,
  input  wire logic                SLEEP_CLOCK_TICK_I,
  input  wire logic                PKT_ACTIVE_I,
  input  wire logic                PKT_TX_I,
  input  wire logic                PKT_RX_I,
  input  wire logic                PKT_HOST_REQ_I,
  input  wire logic [3:0]          S_AXI_AWADDR,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  input  wire bph_pkg::bph_word_t  S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  input  wire logic [3:0]          S_AXI_ARADDR,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  output bph_pkg::bph_word_t       S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY,
  output logic                     HOST_WAKE_OUT_O,
  output logic                     BT_REFCLK_REQUEST_O,
  output logic                     PD_TX_O,
  output logic                     PD_RX_O,
  output logic                     PD_SYN_O,
  output logic                     PD_PA_O,
  output logic                     SYN_RETUNE_O,
  output logic                     ASLEEP_O
);
  import bph_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  bph_word_t  ctrl_reg;
  logic [3:0] pd_reg;
  logic [15:0] sleep_ivl_reg;
  bph_state_t state_reg, state_next;
  logic [15:0] dly_cnt_reg;
  logic [15:0] slp_cnt_reg;
  logic [15:0] hop_cnt_reg;
  logic [6:0]  chan_reg;
  logic        aw_held_reg, w_held_reg;
  logic [3:0]  aw_addr_reg;
  bph_word_t   w_data_reg;
  logic [3:0]  w_strb_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire hs_en      = ctrl_reg[`BPH_CTRL_HS_EN] & UART_MODE_I;
  wire dev_wake   = hs_en & (DEVICE_WAKE_IN_I ^ ctrl_reg[`BPH_CTRL_DW_POL]);
  wire need_host  = ctrl_reg[`BPH_CTRL_HOSTREQ] | PKT_HOST_REQ_I;
  wire pending    = dev_wake | PKT_ACTIVE_I | need_host;
  wire sleep_ok   = ctrl_reg[`BPH_CTRL_SLPOK] & ~PKT_ACTIVE_I;
  wire want_sleep = sleep_ok & ~pending;
  wire slp_done   = SLEEP_CLOCK_TICK_I & (slp_cnt_reg == 16'h0001);
  wire dly_done   = dly_cnt_reg == 16'(CLKREQ_CYC - 1);
  wire hw_assert  = hs_en & need_host & (state_reg == BPH_ST_AWAKE);
  wire clk_need   = ((state_reg == BPH_ST_AWAKE) | WLAN_REFCLK_NEED_I)
                    & (state_reg != BPH_ST_START) & (state_reg != BPH_ST_OFF);
  wire do_wr      = aw_held_reg & w_held_reg & ~S_AXI_BVALID;
  wire wr_ctrl    = do_wr & (aw_addr_reg == `BPH_CTRL_OFS);
  wire wr_pd      = do_wr & (aw_addr_reg == `BPH_PD_OFS);
  wire wr_slp     = do_wr & (aw_addr_reg == `BPH_SLEEP_OFS);
  wire wr_map     = wr_ctrl | wr_pd | wr_slp | (aw_addr_reg == `BPH_STAT_OFS);
  wire go_sleep   = wr_ctrl & w_strb_reg[0] & w_data_reg[`BPH_CTRL_GO_SLEEP];
  // Transmit also needs the amplifier, packet activity needs the synthesizer
  wire [3:0] pd_eff = pd_reg & ~{PKT_TX_I, PKT_ACTIVE_I, PKT_RX_I, PKT_TX_I};
  wire hw_idle    = HOST_WAKE_OUT_O == ctrl_reg[`BPH_CTRL_HW_POL];
  wire asleep     = state_reg == BPH_ST_SLEEP;

  bph_word_t rd_word;
  assign rd_word = (S_AXI_ARADDR == `BPH_CTRL_OFS)  ? ctrl_reg :
                   (S_AXI_ARADDR == `BPH_PD_OFS)    ? {28'h0, pd_reg} :
                   (S_AXI_ARADDR == `BPH_SLEEP_OFS) ? {16'h0, sleep_ivl_reg} :
                   {16'h0, 1'b0, chan_reg, state_reg, dev_wake, need_host,
                    BT_REFCLK_REQUEST_O, HOST_WAKE_OUT_O};
  wire rd_map = (S_AXI_ARADDR == `BPH_CTRL_OFS) | (S_AXI_ARADDR == `BPH_PD_OFS)
              | (S_AXI_ARADDR == `BPH_SLEEP_OFS) | (S_AXI_ARADDR == `BPH_STAT_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BPH_ST_OFF:   state_next = BPH_ST_START;
      BPH_ST_START: if (dly_done) state_next = BPH_ST_AWAKE;
      // Software sleep is refused while a wake or host request is pending
      BPH_ST_AWAKE: if ((go_sleep && !pending) || (want_sleep && hs_en && hw_idle))
                      state_next = BPH_ST_SLEEP;
      BPH_ST_SLEEP: if (dev_wake || PKT_HOST_REQ_I || slp_done)
                      state_next = BPH_ST_AWAKE;
      default:      state_next = BPH_ST_OFF;
    endcase
  end

  // Power enable low holds the state machine in its off state
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg <= BPH_ST_OFF;
    end else if (!BT_POWER_ENABLE_I) begin
      state_reg <= BPH_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dly_cnt_reg <= 16'h0;
    end else if (state_reg != BPH_ST_START) begin
      dly_cnt_reg <= 16'h0;
    end else if (!dly_done) begin
      dly_cnt_reg <= dly_cnt_reg + 16'h1;
    end
  end

  // Sleep interval counts sleep-clock ticks, reloaded on entry
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      slp_cnt_reg <= 16'h0;
    end else if (!asleep) begin
      slp_cnt_reg <= sleep_ivl_reg;
    end else if (SLEEP_CLOCK_TICK_I && slp_cnt_reg > 16'h1) begin
      slp_cnt_reg <= slp_cnt_reg - 16'h1;
    end
  end

  // Hop timer: one retune per slot, channel wraps at the band edge
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hop_cnt_reg  <= 16'h0;
      chan_reg     <= 7'h0;
      SYN_RETUNE_O <= 1'b0;
    end else if (asleep || !BT_POWER_ENABLE_I) begin
      hop_cnt_reg  <= 16'h0;
      SYN_RETUNE_O <= 1'b0;
    end else if (hop_cnt_reg == 16'(HOP_CYC - 1)) begin
      hop_cnt_reg  <= 16'h0;
      SYN_RETUNE_O <= 1'b1;
      chan_reg     <= (chan_reg == 7'(`BPH_CHANNELS - 1)) ? 7'h0 : chan_reg + 7'h1;
    end else begin
      hop_cnt_reg  <= hop_cnt_reg + 16'h1;
      SYN_RETUNE_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs, all registered
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BT_REFCLK_REQUEST_O <= 1'b0;
      HOST_WAKE_OUT_O     <= 1'b0;
      {PD_PA_O, PD_SYN_O, PD_RX_O, PD_TX_O} <= `BPH_PD_RST;
      ASLEEP_O            <= 1'b0;
    end else begin
      BT_REFCLK_REQUEST_O <= BT_POWER_ENABLE_I & clk_need;
      HOST_WAKE_OUT_O     <= hw_assert ^ ctrl_reg[`BPH_CTRL_HW_POL];
      {PD_PA_O, PD_SYN_O, PD_RX_O, PD_TX_O} <=
        (asleep || state_reg != BPH_ST_AWAKE) ? `BPH_PD_RST : pd_eff;
      ASLEEP_O            <= asleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end else if (do_wr) begin
        aw_held_reg <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end else if (do_wr) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `BPH_RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= ~aw_held_reg & ~(S_AXI_AWVALID & S_AXI_AWREADY) & ~S_AXI_BVALID;
      S_AXI_WREADY  <= ~w_held_reg & ~(S_AXI_WVALID & S_AXI_WREADY) & ~S_AXI_BVALID;
      if (do_wr) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_map ? `BPH_RESP_OKAY : `BPH_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Go-sleep bit is a write pulse and never stored
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_reg      <= `BPH_CTRL_RST;
      pd_reg        <= `BPH_PD_RST;
      sleep_ivl_reg <= `BPH_SLEEP_RST;
    end else begin
      if (wr_ctrl && w_strb_reg[0]) ctrl_reg[`BPH_CTRL_SLPOK:0] <= w_data_reg[`BPH_CTRL_SLPOK:0];
      if (wr_pd && w_strb_reg[0]) pd_reg <= w_data_reg[3:0];
      if (wr_slp && w_strb_reg[0]) sleep_ivl_reg[7:0] <= w_data_reg[7:0];
      if (wr_slp && w_strb_reg[1]) sleep_ivl_reg[15:8] <= w_data_reg[15:8];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= `BPH_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_RVALID & ~(S_AXI_ARVALID & S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_map ? rd_word : 32'h0;
        S_AXI_RRESP  <= rd_map ? `BPH_RESP_OKAY : `BPH_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_refclk_reset_low: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !BT_POWER_ENABLE_I |=> !BT_REFCLK_REQUEST_O)
    else $error("clock request high while power enable low");
  a_refclk_delay: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    $rose(BT_POWER_ENABLE_I) |=> !BT_REFCLK_REQUEST_O [*3])
    else $error("clock request rose too early");
  a_unit_held_off: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !BT_POWER_ENABLE_I |=> state_reg == BPH_ST_OFF)
    else $error("unit left off state while power enable low");
  a_wake_leaves_sleep: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (asleep && dev_wake && BT_POWER_ENABLE_I) |=> !asleep)
    else $error("device wake did not end sleep");
  a_sleep_needs_idle: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    $rose(asleep) |-> $past(go_sleep) || $past(want_sleep))
    else $error("sleep entered with criteria unmet");
  a_hostwake_polarity: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    1'b1 |=> HOST_WAKE_OUT_O == ($past(hw_assert) ^ $past(ctrl_reg[`BPH_CTRL_HW_POL])))
    else $error("host wake level wrong");
  a_pd_while_asleep: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    asleep |=> {PD_PA_O, PD_SYN_O, PD_RX_O, PD_TX_O} == `BPH_PD_RST)
    else $error("radio powered during sleep");
  a_hostwake_when_off: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !hs_en |=> HOST_WAKE_OUT_O == $past(ctrl_reg[`BPH_CTRL_HW_POL]))
    else $error("host wake asserted with handshake off");
  c_sleep_wake: cover property (@(posedge CLOCK_I) $rose(asleep) ##[1:1000] $fell(asleep));
  c_refclk_up: cover property (@(posedge CLOCK_I) $rose(BT_REFCLK_REQUEST_O));
  c_retune: cover property (@(posedge CLOCK_I) SYN_RETUNE_O);
endmodule : bph_power_unit
`default_nettype wire

// ---- dv/bph_host_model.sv ----
/*
  Host-side partner: drives the device-wake pin, follows the host-wake pin
  and supplies the reference clock on request.
  Assumes bench commands change just after a rising edge of clk_i.
*/
`default_nettype none
module bph_host_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic want_wake_i,
  input  wire logic dw_low_i,
  input  wire logic hw_low_i,
  input  wire logic host_wake_i,
  input  wire logic refclk_req_i,
  input  wire logic ext_ref_i,
  output logic      dev_wake_o,
  output logic      host_awake_o,
  output logic      refclk_on_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idle_reg;
  wire        hw_act = host_wake_i ^ hw_low_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dev_wake_o   <= 1'b0;
      host_awake_o <= 1'b1;
      idle_reg     <= 4'h0;
    end else begin
      dev_wake_o <= want_wake_i ^ dw_low_i;
      if (hw_act) begin
        host_awake_o <= 1'b1;
        idle_reg     <= 4'h0;
      end else if (idle_reg == 4'hf) begin
        host_awake_o <= 1'b0;
      end else begin
        idle_reg <= idle_reg + 4'h1;
      end
    end
  end
  // Own crystal designs leave ext_ref_i low and ignore the request
  assign refclk_on_o = ext_ref_i & refclk_req_i;
endmodule // bph_host_model
`default_nettype wire

// ---- dv/bph_power_unit_tb.sv ----
/*
  Self-checking bench for the power handshake unit with a host partner.
  Assumes short startup and hop counts set through the parameters.
*/
`default_nettype none
module bph_power_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bph_pkg::*;
  localparam int CQ = 4;
  localparam int HC = 8;
  logic clk = 1'b0, rst_n = 1'b0, pwr = 1'b0, uart = 1'b1, wlan = 1'b0;
  logic tick = 1'b0, pact = 1'b0, ptx = 1'b0, prx = 1'b0, preq = 1'b0;
  logic want = 1'b0, dwl = 1'b0, hwl = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  bph_word_t  wdata = '0, rdata;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic awr, wr_rdy, bv, arr, rv, hwake, creq, retune, asleep, dwake, hawake, refon;
  logic pd_tx, pd_rx, pd_syn, pd_pa;
  logic [1:0] bresp, rresp;
  int fail_count = 0;
  int n_tests = 0;

  always #25 clk = ~clk;

  bph_power_unit #(.CLKREQ_CYC(CQ), .HOP_CYC(HC)) bph_power_unit_i (
    .CLOCK_I(clk), .RST_N_I(rst_n), .BT_POWER_ENABLE_I(pwr), .UART_MODE_I(uart),
    .DEVICE_WAKE_IN_I(dwake), .WLAN_REFCLK_NEED_I(wlan), .SLEEP_CLOCK_TICK_I(tick),
    .PKT_ACTIVE_I(pact), .PKT_TX_I(ptx), .PKT_RX_I(prx), .PKT_HOST_REQ_I(preq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy),
    .HOST_WAKE_OUT_O(hwake), .BT_REFCLK_REQUEST_O(creq), .PD_TX_O(pd_tx),
    .PD_RX_O(pd_rx), .PD_SYN_O(pd_syn), .PD_PA_O(pd_pa), .SYN_RETUNE_O(retune),
    .ASLEEP_O(asleep));

  bph_host_model bph_host_model_i (
    .clk_i(clk), .rst_n_i(rst_n), .want_wake_i(want), .dw_low_i(dwl), .hw_low_i(hwl),
    .host_wake_i(hwake), .refclk_req_i(creq), .ext_ref_i(1'b1), .dev_wake_o(dwake),
    .host_awake_o(hawake), .refclk_on_o(refon));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input bph_word_t got, input bph_word_t exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic complete_run;
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Ready is looked at on the falling edge, where it equals the next rising edge
  task automatic wr(input logic [3:0] a, input bph_word_t d, output logic [1:0] r);
    logic ta, tw, gb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv & (awr === 1'b1);
      tw = wv & (wr_rdy === 1'b1);
      gb = (bv === 1'b1);
      r = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!gb);
    brdy <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output bph_word_t d, output logic [1:0] r);
    logic ta, gr;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(negedge clk);
      ta = arv & (arr === 1'b1);
      gr = (rv === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end while (!gr);
    rrdy <= 1'b0;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return asleep;
      1: return creq;
      default: return retune;
    endcase
  endfunction

  task automatic wait_sig(input int s, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sig(s) !== v && n < lim);
  endtask

  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic [1:0] r;
    bph_word_t d, v;
    void'($urandom(32'h136d));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(creq, 0, "clock request before power");
    @(posedge clk) pwr <= 1'b1;
    wait_sig(1, 1'b1, CQ + 10, n);
    chk(n >= CQ && n <= CQ + 3, 1, "clock request delay");
    rd(4'h0, d, r);
    chk(d, 32'h1, "ctrl reset");
    rd(4'hc, d, r);
    chk(d, 32'h20, "sleep interval reset");
    rd(4'h8, d, r);
    chk(d[1], 1, "status clock request");
    rd(4'h2, d, r);
    chk(r, 2'b10, "unmapped response");
    wr(4'h2, 32'h0, r);
    chk(r, 2'b10, "unmapped write response");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'hf : (i == 1) ? 32'h0 : ($urandom & 32'hf);
      wr(4'h4, v, r);
      chk(r, 2'b00, "write response");
      rd(4'h4, d, r);
      chk(d, v, "pd readback");
      chk({pd_pa, pd_syn, pd_rx, pd_tx}, v, "pd pins");
    end
    wr(4'h4, 32'hf, r);
    ptx <= 1'b1;
    prx <= 1'b1;
    pact <= 1'b1;
    repeat (3) @(negedge clk);
    chk({pd_pa, pd_syn, pd_rx, pd_tx}, 0, "packet powers paths");
    @(posedge clk) {ptx, prx, pact} <= 3'b000;
    repeat (3) @(negedge clk);
    chk({pd_pa, pd_syn, pd_rx, pd_tx}, 4'hf, "paths back down");
    wr(4'h4, 32'h0, r);
    wait_sig(2, 1'b1, HC + 4, n);
    wait_sig(2, 1'b1, HC + 4, n);
    chk(n, HC, "hop spacing");
    for (int p = 0; p < 2; p++) begin
      hwl <= p[0];
      wr(4'h0, 32'h9 | (p << 2), r);
      repeat (3) @(negedge clk);
      chk(hwake, !p, "host wake asserted");
      chk(hawake, 1, "host kept awake");
      wr(4'h0, 32'h1 | (p << 2), r);
      repeat (3) @(negedge clk);
      chk(hwake, p, "host wake released");
    end
    repeat (20) @(negedge clk);
    chk(hawake, 0, "host may sleep");
    hwl <= 1'b0;
    wr(4'h0, 32'h1, r);
    preq <= 1'b1;
    repeat (3) @(negedge clk);
    chk(hwake, 1, "packet host request");
    @(posedge clk) preq <= 1'b0;
    wr(4'h0, 32'h21, r);
    wait_sig(0, 1'b1, 6, n);
    chk(asleep, 1, "software sleep");
    chk(hwake, 0, "host wake released in sleep");
    @(posedge clk) preq <= 1'b1;
    wait_sig(0, 1'b0, 6, n);
    chk(asleep, 0, "packet wake");
    @(posedge clk) preq <= 1'b0;
    wr(4'hc, 32'h3, r);
    for (int p = 0; p < 2; p++) begin
      dwl <= p[0];
      wr(4'h0, 32'h11 | (p << 1), r);
      wait_sig(0, 1'b1, 40, n);
      chk(asleep, 1, "auto sleep");
      chk(hwake, 0, "host wake idle in sleep");
      chk(creq, 0, "no clock request asleep");
      @(posedge clk) wlan <= 1'b1;
      repeat (2) @(negedge clk);
      chk(creq, 1, "wlan clock request");
      chk(refon, 1, "host supplies clock");
      @(posedge clk) wlan <= 1'b0;
      ticks(2);
      @(negedge clk);
      chk(asleep, 1, "interval not yet over");
      // Unit goes straight back to sleep, so watch the one-cycle wake
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
      wait_sig(0, 1'b0, 4, n);
      chk(asleep, 0, "interval wake");
      wait_sig(0, 1'b1, 40, n);
      @(posedge clk) uart <= 1'b0;
      want <= 1'b1;
      repeat (10) @(negedge clk);
      chk(asleep, 1, "wake ignored outside uart");
      @(posedge clk) uart <= 1'b1;
      wait_sig(0, 1'b0, 6, n);
      chk(asleep, 0, "device wake");
      repeat (20) @(negedge clk);
      chk(asleep, 0, "kept awake");
      @(posedge clk) want <= 1'b0;
    end
    @(posedge clk) pwr <= 1'b0;
    repeat (3) @(negedge clk);
    chk({creq, asleep}, 0, "power enable low");
    complete_run;
  end

  // Whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run;
  end
endmodule // bph_power_unit_tb
`default_nettype wire
